// *** ces_pkg.sv ***
// shared constants, register map and carrier types for the can event/status/interrupt block
`default_nettype none

package ces_pkg;

	// ==========================================================
	// sizes
	localparam int CES_NUM_MB = 8;
	localparam int CES_ADDR_W = 8;
	localparam int CES_DATA_W = 32;
	localparam int CES_CNT_W = 9;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [CES_ADDR_W-1:0] CES_OFS_MODE = 8'h00;
	localparam logic [CES_ADDR_W-1:0] CES_OFS_IRQ_SET = 8'h04;
	localparam logic [CES_ADDR_W-1:0] CES_OFS_IRQ_CLR = 8'h08;
	localparam logic [CES_ADDR_W-1:0] CES_OFS_IRQ_MASK = 8'h0C;
	localparam logic [CES_ADDR_W-1:0] CES_OFS_STATUS = 8'h10;

	// ==========================================================
	// mode register fields
	localparam int CES_MODE_RETRY_DIS_BIT = 7;
	localparam int CES_MODE_SYNC_LSB = 24;
	localparam int CES_SYNC_W = 2;
	localparam logic CES_RETRY_DIS_RST = 1'h0;

	// ==========================================================
	// common layout of set, clear, mask and status words
	localparam int CES_SR_MB_LSB = 0;
	localparam int CES_SR_ERR_ACT = 16;
	localparam int CES_SR_WARN = 17;
	localparam int CES_SR_ERR_PAS = 18;
	localparam int CES_SR_BUS_OFF = 19;
	localparam int CES_SR_SLEEP = 20;
	localparam int CES_SR_WAKEUP = 21;
	localparam int CES_SR_TMR_OVF = 22;
	localparam int CES_SR_TSTAMP = 23;
	localparam int CES_SR_PERR_LSB = 24;
	localparam int CES_SR_RBSY = 29;
	localparam int CES_SR_TBSY = 30;
	localparam int CES_SR_OVLSY = 31;

	// bits that hold a mask flop; the rest read zero
	localparam logic [CES_DATA_W-1:0] CES_MASK_IMPL = 32'h1FFF_00FF;
	localparam logic [CES_DATA_W-1:0] CES_MASK_RST = 32'h0000_0000;
	localparam logic [CES_DATA_W-1:0] CES_WORD_ZERO = 32'h0000_0000;

	// ==========================================================
	// fault confinement limits
	localparam logic [CES_CNT_W-1:0] CES_WARN_LIMIT = 9'h060;
	localparam logic [CES_CNT_W-1:0] CES_PASSIVE_LIMIT = 9'h080;
	localparam logic [CES_CNT_W-1:0] CES_BUSOFF_LIMIT = 9'h100;

	// ==========================================================
	// types
	typedef enum logic [CES_SYNC_W-1:0] {
		CES_SYNC_POS2 = 2'b00,
		CES_SYNC_POS_NEG = 2'b01,
		CES_SYNC_POS1 = 2'b10,
		CES_SYNC_NONE = 2'b11
	} ces_sync_e;

	typedef struct packed {
		logic [CES_ADDR_W-1:0] addr;
		logic [CES_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} ces_bus_s;

	// msb first, so the struct drops straight onto status bits 28..24
	typedef struct packed {
		logic bit_err;
		logic form_err;
		logic ack_err;
		logic stuff_err;
		logic crc_err;
	} ces_proto_err_s;

	typedef struct packed {
		logic [CES_NUM_MB-1:0] req_set;
		logic [CES_NUM_MB-1:0] arb_lost;
		logic [CES_NUM_MB-1:0] tx_done;
		logic [CES_NUM_MB-1:0] rx_done;
		logic [CES_NUM_MB-1:0] flag_clr;
	} ces_mb_evt_s;

	typedef struct packed {
		logic ovl_busy;
		logic tx_busy;
		logic rx_busy;
		logic wakeup;
		logic sleep;
	} ces_link_state_s;

endpackage : ces_pkg

`default_nettype wire

// *** ces_rx_sync.sv ***
// selectable synchroniser for the can receive input
`timescale 1ns/1ps
`default_nettype none

module ces_rx_sync
	import ces_pkg::*;
(
	input wire logic clock, // core clock
	input wire logic sys_rst, // sync reset, active high
	input wire ces_pkg::ces_sync_e sel, // stage selection
	input wire logic rx_pin, // raw receive pin
	output logic rx_out // receive level to the core
);

	// ==========================================================
	// separate chains so each first stage feeds only its second
	logic pos2_a_reg;
	logic pos2_b_reg;
	logic mix_a_reg;
	logic mix_b_reg;
	logic one_reg;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pos2_a_reg <= 1'h1;
			pos2_b_reg <= 1'h1;
			mix_a_reg <= 1'h1;
			one_reg <= 1'h1;
		end else begin
			pos2_a_reg <= rx_pin;
			pos2_b_reg <= pos2_a_reg;
			mix_a_reg <= rx_pin;
			one_reg <= rx_pin;
		end
	end

	// half-cycle second stage: less latency, less settling time
	always_ff @(negedge clock) begin
		if (sys_rst) begin
			mix_b_reg <= 1'h1;
		end else begin
			mix_b_reg <= mix_a_reg;
		end
	end

	always_comb begin
		unique case (sel)
			CES_SYNC_POS2: rx_out = pos2_b_reg;
			CES_SYNC_POS_NEG: rx_out = mix_b_reg;
			CES_SYNC_POS1: rx_out = one_reg;
			CES_SYNC_NONE: rx_out = rx_pin;
		endcase
	end

endmodule : ces_rx_sync

`default_nettype wire

// *** ces_status_irq.sv ***
// can controller interrupt enable/mask/status, retry option and rx synchroniser selection
//
// Contract
// - retry allowed: lost arbitration keeps the mailbox transmit request pending
// - retry disabled: lost arbitration cancels request, raises abort and ready flags
// - sync select 0 two rising, 1 rising+falling, 2 one rising, else bypass
// - sync selection is write-only; its bits read back as zero
// - writing one to enable-set sets that mask bit; zero leaves it
// - writing one to enable-clear clears that mask bit; zero leaves it
// - mask view reads one per enabled source, zero per disabled
// - bits 16..23: error-active, warning, passive, bus-off, sleep, wakeup, overflow, timestamp
// - bits 24..28: crc, stuffing, acknowledge, form, bit error
// - status bits 0..7 report mailbox ready or abort flag set
// - error-active flag set exactly while neither passive nor bus-off
// - warning flag set while either error counter exceeds 96
// - passive flag set while either error counter is at least 128
// - bus-off flag set while transmit error counter is at least 256
// - protocol error and overflow flags clear when status is read
`timescale 1ns/1ps
`default_nettype none

module ces_status_irq
	import ces_pkg::*;
#(
	parameter int NUM_MB = CES_NUM_MB // number of mailboxes
) (
	input wire logic clock, // 40 MHz core clock
	input wire logic sys_rst, // sync reset, active high
	input wire ces_pkg::ces_bus_s bus, // register port request
	output logic [CES_DATA_W-1:0] rd_data, // read data, cycle after read
	output logic irq, // controller interrupt level
	input wire ces_pkg::ces_mb_evt_s mb_evt, // mailbox event pulses
	output logic [NUM_MB-1:0] mb_tx_pending, // transmit request pending
	output logic [NUM_MB-1:0] mb_ready_flag, // mailbox ready flag
	output logic [NUM_MB-1:0] mb_abort_flag, // mailbox abort flag
	input wire logic [CES_CNT_W-1:0] transmit_error_count, // tx error count
	input wire logic [CES_CNT_W-1:0] receive_error_count, // rx error count
	input wire logic timer_overflow_evt, // timer rolled over, pulse
	input wire logic timestamp_evt, // frame start/end seen, pulse
	input wire ces_pkg::ces_proto_err_s proto_err, // protocol error pulses
	input wire ces_pkg::ces_link_state_s link_state, // sleep/wakeup/busy levels
	input wire logic can_rx_pin, // raw receive pin
	output logic can_rx_synced, // receive level after sync
	output logic arbitration_retry_disable // retry option to the transmitter
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [CES_DATA_W-1:0] mask;
		logic retry_dis;
		ces_sync_e sync_sel;
		logic [NUM_MB-1:0] pending;
		logic [NUM_MB-1:0] ready;
		logic [NUM_MB-1:0] abort;
		logic err_act;
		logic warn;
		logic err_pas;
		logic bus_off;
		logic tmr_ovf;
		logic tstamp;
		ces_proto_err_s perr;
		ces_link_state_s link;
		logic [CES_DATA_W-1:0] rdata;
		logic irq;
	} ces_state_s;

	ces_state_s st_reg;
	ces_state_s st_next;

	// ==========================================================
	// bus decode
	logic wr_mode;
	logic wr_set;
	logic wr_clr;
	logic wr_stat;
	logic rd_stat;

	assign wr_mode = bus.wr && (bus.addr == CES_OFS_MODE);
	assign wr_set = bus.wr && (bus.addr == CES_OFS_IRQ_SET);
	assign wr_clr = bus.wr && (bus.addr == CES_OFS_IRQ_CLR);
	assign wr_stat = bus.wr && (bus.addr == CES_OFS_STATUS);
	assign rd_stat = bus.rd && (bus.addr == CES_OFS_STATUS);

	// ==========================================================
	// per-mailbox request and flag logic
	logic [NUM_MB-1:0] pend_nx;
	logic [NUM_MB-1:0] ready_nx;
	logic [NUM_MB-1:0] abort_nx;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_MB; gi++) begin : g_mb
			logic lost;
			logic drop;

			assign lost = mb_evt.arb_lost[gi] && st_reg.pending[gi];
			// cancel only when retry is off
			assign drop = lost && st_reg.retry_dis;

			// a fresh request wins over a same-cycle cancel or completion
			assign pend_nx[gi] = mb_evt.req_set[gi] ||
				(st_reg.pending[gi] && !drop && !mb_evt.tx_done[gi]);

			// set wins over the clear from a new mailbox command
			assign ready_nx[gi] = drop || mb_evt.tx_done[gi] ||
				mb_evt.rx_done[gi] ||
				(st_reg.ready[gi] && !mb_evt.flag_clr[gi]);

			assign abort_nx[gi] = drop ||
				(st_reg.abort[gi] && !mb_evt.flag_clr[gi]);
		end
	endgenerate

	// ==========================================================
	// fault confinement levels from the error counters
	logic warn_now;
	logic passive_now;
	logic busoff_now;

	assign warn_now = (transmit_error_count > CES_WARN_LIMIT) ||
		(receive_error_count > CES_WARN_LIMIT);
	assign passive_now = (transmit_error_count >= CES_PASSIVE_LIMIT) ||
		(receive_error_count >= CES_PASSIVE_LIMIT);
	assign busoff_now = transmit_error_count >= CES_BUSOFF_LIMIT;

	// ==========================================================
	// status word as seen by software
	logic [CES_DATA_W-1:0] status_word;

	always_comb begin
		status_word = CES_WORD_ZERO;
		status_word[CES_SR_MB_LSB +: NUM_MB] = st_reg.ready | st_reg.abort;
		status_word[CES_SR_ERR_ACT] = st_reg.err_act;
		status_word[CES_SR_WARN] = st_reg.warn;
		status_word[CES_SR_ERR_PAS] = st_reg.err_pas;
		status_word[CES_SR_BUS_OFF] = st_reg.bus_off;
		status_word[CES_SR_SLEEP] = st_reg.link.sleep;
		status_word[CES_SR_WAKEUP] = st_reg.link.wakeup;
		status_word[CES_SR_TMR_OVF] = st_reg.tmr_ovf;
		status_word[CES_SR_TSTAMP] = st_reg.tstamp;
		status_word[CES_SR_PERR_LSB +: $bits(ces_proto_err_s)] = st_reg.perr;
		status_word[CES_SR_RBSY] = st_reg.link.rx_busy;
		status_word[CES_SR_TBSY] = st_reg.link.tx_busy;
		status_word[CES_SR_OVLSY] = st_reg.link.ovl_busy;
	end

	// ==========================================================
	// sticky event flags
	// cleared by a status read, or by writing one to the status offset;
	// an event in the clearing cycle still lands
	logic [$bits(ces_proto_err_s)-1:0] perr_clr;
	logic tmr_ovf_clr;
	logic tstamp_clr;

	always_comb begin
		perr_clr = {$bits(ces_proto_err_s){rd_stat}} |
			({$bits(ces_proto_err_s){wr_stat}} &
			bus.wdata[CES_SR_PERR_LSB +: $bits(ces_proto_err_s)]);
		tmr_ovf_clr = rd_stat || (wr_stat && bus.wdata[CES_SR_TMR_OVF]);
		tstamp_clr = rd_stat || (wr_stat && bus.wdata[CES_SR_TSTAMP]);
	end

	// ==========================================================
	// read data, registered so it stands in the cycle after the strobe
	logic [CES_DATA_W-1:0] rd_word;

	always_comb begin
		rd_word = CES_WORD_ZERO;
		if (bus.rd) begin
			unique case (bus.addr)
				// sync selection is not readable: only the retry bit shows
				CES_OFS_MODE: rd_word[CES_MODE_RETRY_DIS_BIT] = st_reg.retry_dis;
				CES_OFS_IRQ_MASK: rd_word = st_reg.mask & CES_MASK_IMPL;
				CES_OFS_STATUS: rd_word = status_word;
				default: rd_word = CES_WORD_ZERO;
			endcase
		end
	end

	// ==========================================================
	// next state
	always_comb begin
		st_next = st_reg;

		// mode register
		if (wr_mode) begin
			st_next.retry_dis = bus.wdata[CES_MODE_RETRY_DIS_BIT];
			st_next.sync_sel = ces_sync_e'(bus.wdata[CES_MODE_SYNC_LSB +: CES_SYNC_W]);
		end

		// interrupt mask: set and clear registers touch only written ones
		if (wr_set) begin
			st_next.mask = st_reg.mask | (bus.wdata & CES_MASK_IMPL);
		end
		if (wr_clr) begin
			st_next.mask = st_reg.mask & ~bus.wdata;
		end

		// mailboxes
		st_next.pending = pend_nx;
		st_next.ready = ready_nx;
		st_next.abort = abort_nx;

		// level flags follow the counters, one cycle behind
		st_next.err_act = !passive_now && !busoff_now;
		st_next.warn = warn_now;
		st_next.err_pas = passive_now;
		st_next.bus_off = busoff_now;
		st_next.link = link_state;

		// sticky events
		st_next.tmr_ovf = timer_overflow_evt || (st_reg.tmr_ovf && !tmr_ovf_clr);
		st_next.tstamp = timestamp_evt || (st_reg.tstamp && !tstamp_clr);
		st_next.perr = proto_err | (st_reg.perr & ~perr_clr);

		// outputs
		st_next.rdata = rd_word;
		st_next.irq = |(status_word & st_reg.mask);
	end

	// ==========================================================
	// registers
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_reg.mask <= CES_MASK_RST;
			st_reg.retry_dis <= CES_RETRY_DIS_RST;
			st_reg.sync_sel <= CES_SYNC_POS2;
			st_reg.pending <= '0;
			st_reg.ready <= '0;
			st_reg.abort <= '0;
			st_reg.err_act <= 1'h1;
			st_reg.warn <= 1'h0;
			st_reg.err_pas <= 1'h0;
			st_reg.bus_off <= 1'h0;
			st_reg.tmr_ovf <= 1'h0;
			st_reg.tstamp <= 1'h0;
			st_reg.perr <= '0;
			st_reg.link <= '0;
			st_reg.rdata <= CES_WORD_ZERO;
			st_reg.irq <= 1'h0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// receive synchroniser
	ces_rx_sync u_rx_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.sel(st_reg.sync_sel),
		.rx_pin(can_rx_pin),
		.rx_out(can_rx_synced)
	);

	// ==========================================================
	// outputs
	assign rd_data = st_reg.rdata;
	assign irq = st_reg.irq;
	assign mb_tx_pending = st_reg.pending;
	assign mb_ready_flag = st_reg.ready;
	assign mb_abort_flag = st_reg.abort;
	assign arbitration_retry_disable = st_reg.retry_dis;

endmodule : ces_status_irq

`default_nettype wire

// *** ces_bus_node.sv ***
// far-side bus model: wired-and can line seen by the receive pin
`timescale 1ns/1ps
`default_nettype none

module ces_bus_node (
	input wire logic dominant, // bench asks this node to pull the line low
	output logic rx_level // line level at the receive pin
);
	// recessive pull-up: with no node pulling low the line reads one
	assign rx_level = ~dominant;
endmodule : ces_bus_node

`default_nettype wire

// *** ces_checker.sv ***
// concurrent checks on the ports of the can status and interrupt block
`timescale 1ns/1ps
`default_nettype none

module ces_checker
	import ces_pkg::*;
#(
	parameter int NUM_MB = CES_NUM_MB // number of mailboxes
) (
	input wire logic clock, // core clock
	input wire logic sys_rst, // sync reset
	input wire ces_pkg::ces_bus_s bus, // register request
	input wire logic [CES_DATA_W-1:0] rd_data, // read data
	input wire logic irq, // interrupt level
	input wire ces_pkg::ces_mb_evt_s mb_evt, // mailbox pulses
	input wire logic [NUM_MB-1:0] mb_tx_pending, // pending requests
	input wire logic [NUM_MB-1:0] mb_ready_flag, // ready flags
	input wire logic [NUM_MB-1:0] mb_abort_flag, // abort flags
	input wire logic arbitration_retry_disable // retry option
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	// ==========================================================
	// helpers
	logic [NUM_MB-1:0] lost_keep;
	logic [NUM_MB-1:0] lost_drop;
	logic [NUM_MB-1:0] done;
	assign lost_keep = mb_evt.arb_lost[NUM_MB-1:0] & mb_tx_pending
		& ~mb_evt.tx_done[NUM_MB-1:0] & {NUM_MB{~arbitration_retry_disable}};
	assign lost_drop = mb_evt.arb_lost[NUM_MB-1:0] & mb_tx_pending
		& ~mb_evt.req_set[NUM_MB-1:0] & {NUM_MB{arbitration_retry_disable}};
	assign done = mb_evt.tx_done[NUM_MB-1:0] | mb_evt.rx_done[NUM_MB-1:0];
	sequence s_status_read;
		bus.rd && bus.addr == CES_OFS_STATUS;
	endsequence
	sequence s_clear_all;
		bus.wr && bus.addr == CES_OFS_IRQ_CLR && (bus.wdata & CES_MASK_IMPL) == CES_MASK_IMPL;
	endsequence
	// ==========================================================
	// assertions
	a_retry_keeps_pending: assert property (lost_keep != 0 |=>
		(mb_tx_pending & $past(lost_keep)) == $past(lost_keep)) else $error("pending lost");
	a_abort_on_loss: assert property (lost_drop != 0 |=>
		(mb_tx_pending & $past(lost_drop)) == 0 &&
		(mb_abort_flag & mb_ready_flag & $past(lost_drop)) == $past(lost_drop))
		else $error("loss not aborted");
	a_retry_option_wr: assert property (bus.wr && bus.addr == CES_OFS_MODE |=>
		arbitration_retry_disable == $past(bus.wdata[CES_MODE_RETRY_DIS_BIT]))
		else $error("retry option not stored");
	a_sync_unreadable: assert property (bus.rd && bus.addr == CES_OFS_MODE |=>
		rd_data[CES_MODE_SYNC_LSB +: CES_SYNC_W] == '0) else $error("sync select readable");
	a_mask_view_bits: assert property (bus.rd && bus.addr == CES_OFS_IRQ_MASK |=>
		(rd_data & ~CES_MASK_IMPL) == CES_WORD_ZERO) else $error("mask view stray bit");
	a_error_active_rel: assert property (s_status_read |=>
		rd_data[CES_SR_ERR_ACT] == !(rd_data[CES_SR_ERR_PAS] || rd_data[CES_SR_BUS_OFF]))
		else $error("error active flag wrong");
	a_irq_drops_off: assert property (s_clear_all |-> ##2 !irq)
		else $error("irq stays with all masked");
	a_done_sets_ready: assert property (done != 0 |=>
		(mb_ready_flag & $past(done)) == $past(done)) else $error("ready not set");
	a_rd_idle_zero: assert property (!bus.rd |=> rd_data == CES_WORD_ZERO)
		else $error("read data without read");
endmodule : ces_checker

bind ces_status_irq ces_checker #(.NUM_MB(NUM_MB)) ces_checker_i (.clock, .sys_rst, .bus,
	.rd_data, .irq, .mb_evt, .mb_tx_pending, .mb_ready_flag, .mb_abort_flag,
	.arbitration_retry_disable);

`default_nettype wire

// *** test_can_event_status_irq.sv ***
// self-checking bench for the can status and interrupt block
`timescale 1ns/1ps
`default_nettype none

module test_can_event_status_irq;
	import ces_pkg::*;
	typedef struct {
		logic [CES_CNT_W-1:0] tx_cnt;
		logic [CES_CNT_W-1:0] rx_cnt;
		logic [3:0] flags; // bus-off, passive, warning, active
	} ces_row_s;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	ces_bus_s bus = '0;
	ces_mb_evt_s mb_evt = '0;
	ces_proto_err_s proto_err = '0;
	ces_link_state_s link_state = '0;
	logic [CES_CNT_W-1:0] tx_cnt = '0;
	logic [CES_CNT_W-1:0] rx_cnt = '0;
	logic tmr_ovf = 1'b0;
	logic tstamp = 1'b0;
	logic dom = 1'b0;
	logic can_rx_pin;
	logic can_rx_synced;
	logic irq;
	logic arbitration_retry_disable;
	logic [CES_DATA_W-1:0] rd_data;
	logic [CES_DATA_W-1:0] st;
	logic [7:0] pend;
	logic [7:0] rdy;
	logic [7:0] abt;
	int n_fail = 0;
	int n_compared = 0;
	int cycles = 0;
	int lat [4] = '{4, 3, 2, 0}; // half cycles until the synced level follows
	ces_row_s rows [11] = '{'{9'h000, 9'h000, 4'h1}, '{9'h060, 9'h000, 4'h1},
		'{9'h061, 9'h000, 4'h3}, '{9'h000, 9'h061, 4'h3}, '{9'h07F, 9'h000, 4'h3},
		'{9'h080, 9'h000, 4'h6}, '{9'h000, 9'h080, 4'h6}, '{9'h0FF, 9'h000, 4'h6},
		'{9'h000, 9'h0FF, 4'h6}, '{9'h100, 9'h000, 4'hE}, '{9'h000, 9'h100, 4'h6}};

	ces_status_irq ces_status_irq_i (.clock, .sys_rst, .bus, .rd_data, .irq, .mb_evt,
		.mb_tx_pending(pend), .mb_ready_flag(rdy), .mb_abort_flag(abt),
		.transmit_error_count(tx_cnt), .receive_error_count(rx_cnt),
		.timer_overflow_evt(tmr_ovf), .timestamp_evt(tstamp), .proto_err, .link_state,
		.can_rx_pin, .can_rx_synced,
		.arbitration_retry_disable);
	ces_bus_node ces_bus_node_i (.dominant(dom), .rx_level(can_rx_pin));

	always #12.5 clock = ~clock;
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_fail++;
			close_out();
		end
	end
	// ==========================================================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [CES_ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clock);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [CES_ADDR_W-1:0] a, output logic [31:0] d);
		@(posedge clock);
		bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus.rd <= 1'b0;
		#1;
		d = rd_data;
	endtask : rd
	// one event pulse, then time for flags, status and irq to settle
	task automatic mb(input ces_mb_evt_s e);
		@(posedge clock);
		mb_evt <= e;
		@(posedge clock);
		mb_evt <= '0;
		repeat (4) @(posedge clock);
		#1;
	endtask : mb
	task automatic close_out;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	// ==========================================================
	// sequence
	initial begin
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		rd(CES_OFS_IRQ_MASK, st);
		chk(st, CES_MASK_RST);
		wr(CES_OFS_IRQ_SET, 32'hFFFF_FFFF);
		rd(CES_OFS_IRQ_MASK, st);
		chk(st, CES_MASK_IMPL);
		wr(CES_OFS_IRQ_SET, 32'h0000_0000);
		wr(CES_OFS_IRQ_CLR, 32'h0001_0001);
		rd(CES_OFS_IRQ_MASK, st);
		chk(st, CES_MASK_IMPL & ~32'h0001_0001);
		repeat (3) @(posedge clock);
		#1;
		chk({31'h0, irq}, 32'h0);
		wr(CES_OFS_IRQ_SET, 32'h0001_0000);
		repeat (3) @(posedge clock);
		#1;
		chk({31'h0, irq}, 32'h1);
		wr(CES_OFS_IRQ_CLR, 32'hFFFF_FFFF);
		rd(CES_OFS_IRQ_MASK, st);
		chk(st, 32'h0000_0000);
		foreach (rows[i]) begin
			@(posedge clock);
			tx_cnt <= rows[i].tx_cnt;
			rx_cnt <= rows[i].rx_cnt;
			repeat (2) @(posedge clock);
			rd(CES_OFS_STATUS, st);
			chk({28'h0, st[19:16]}, {28'h0, rows[i].flags});
		end
		for (int k = 0; k < 7; k++) begin
			@(posedge clock);
			{proto_err, tstamp, tmr_ovf} <= 7'(1 << k);
			@(posedge clock);
			{proto_err, tstamp, tmr_ovf} <= 7'h00;
			repeat (2) @(posedge clock);
			rd(CES_OFS_STATUS, st);
			chk(st & 32'h1FC0_0000, 32'h1 << (22 + k));
			rd(CES_OFS_STATUS, st);
			chk(st & 32'h1FC0_0000, 32'h0);
		end
		// write-one clear at the status offset: a one on another bit must not clear
		for (int w = 0; w < 2; w++) begin
			@(posedge clock);
			tmr_ovf <= 1'b1;
			@(posedge clock);
			tmr_ovf <= 1'b0;
			wr(CES_OFS_STATUS, 32'h0080_0000 >> w);
			rd(CES_OFS_STATUS, st);
			chk(st & 32'h0040_0000, 32'h0040_0000 >> (23 * w));
		end
		@(posedge clock);
		link_state <= '1;
		tx_cnt <= '0;
		rx_cnt <= '0;
		repeat (2) @(posedge clock);
		rd(CES_OFS_STATUS, st);
		chk(st & 32'hE030_0000, 32'hE030_0000);
		@(posedge clock);
		link_state <= '0;
		wr(CES_OFS_IRQ_SET, 32'h0000_0008);
		mb('{req_set: 8'h08, default: '0});
		mb('{arb_lost: 8'h08, default: '0});
		chk({8'h0, pend, rdy, abt}, 32'h0008_0000);
		wr(CES_OFS_MODE, 32'h0000_0080);
		mb('{arb_lost: 8'h08, default: '0});
		chk({7'h0, arbitration_retry_disable, pend, rdy, abt}, 32'h0100_0808);
		chk({31'h0, irq}, 32'h1);
		rd(CES_OFS_STATUS, st);
		chk({24'h0, st[7:0]}, 32'h0000_0008);
		mb('{flag_clr: 8'h08, default: '0});
		chk({15'h0, irq, rdy, abt}, 32'h0);
		mb('{rx_done: 8'h81, default: '0});
		chk({24'h0, rdy}, 32'h0000_0081);
		// lost arbitration on an idle mailbox must not abort it
		mb('{req_set: 8'h10, arb_lost: 8'h02, default: '0});
		mb('{tx_done: 8'h10, default: '0});
		chk({8'h0, pend, rdy, abt}, 32'h0000_9100);
		// stage count is only visible as delay, so time the pin to the synced copy
		for (int s = 0; s < 4; s++) begin
			wr(CES_OFS_MODE, 32'h0000_0080 | (32'(s) << CES_MODE_SYNC_LSB));
			repeat (3) @(posedge clock);
			dom <= ~dom;
			#1;
			for (int h = 0; h < 5; h++) begin
				chk({31'h0, can_rx_synced}, {31'h0, (h >= lat[s]) ? can_rx_pin : ~can_rx_pin});
				#12.5;
			end
		end
		rd(CES_OFS_MODE, st);
		chk(st, 32'h0000_0080);
		// mid-run reset with mask bit 3 and ready flags still set
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		#1;
		chk({6'h0, irq, arbitration_retry_disable, pend, rdy, abt}, 32'h0);
		rd(CES_OFS_IRQ_MASK, st);
		chk(st, CES_MASK_RST);
		rd(CES_OFS_STATUS, st);
		chk(st, 32'h0001_0000);
		close_out();
	end
endmodule : test_can_event_status_irq

`default_nettype wire
